/* ccdf_data_buffer.sv */
// Shared transmit/receive byte buffer of the memory-card controller, with its register slave
// Functional notes
// - One 32-entry byte buffer serves both card reads and card writes.
// - Lowest bus byte maps to the first buffer position, both directions.
// - Transmit port writes push bytes; receive port reads pop bytes.
// - Full flag when write pointer plus width margin passes read pointer.
// - Empty flag when write pointer minus width margin is below read pointer.
// - Occupancy against programmed level raises DMA requests and interrupts.
// - Last byte of the programmed blocks also raises a receive DMA request.
// - Each receive request sets receive-ready flag and masked interrupt.
// - Writes of 1 to 4 bytes; processor 16-bit, DMA 32-bit accesses.
// - First transmit DMA request comes from the kick bit after the command.
// - Below level: one transmit request, then none until DMA completes.
// - Keep feeding card logic during DMA; tell it when buffer runs dry.
// - Each transmit request sets transmit-ready flag and masked interrupt.
// - Processor mode interrupts every 128 or 256 bits received; transmit rearms only on DMA done.
// - A software reset clears the buffer pointers but leaves configuration untouched.
// - Hardware reset returns every register to its default.
// - Enabled edge on third data line sets flag and masked interrupt.
// - Width bit clear selects 1-bit data bus, set selects 4-bit.
// - Card clock is function clock divided by twice the rate field plus two.
// - With clock enable clear, card clock runs only while a transfer needs it.
`timescale 1ns/1ps
`include "ccdf_cfg.svh"

module ccdf_data_buffer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic dma_tx_req_o,
  output logic dma_rx_req_o,
  input wire logic dma_done_i,
  output logic tx_ready_irq_o,
  output logic rx_ready_irq_o,
  output logic edge_irq_o,
  output logic card_tx_valid_o,
  output logic [7:0] card_tx_data_o,
  input wire logic card_tx_take_i,
  output logic card_tx_dry_o,
  input wire logic card_rx_valid_i,
  input wire logic [7:0] card_rx_data_i,
  output logic card_rx_ready_o,
  input wire logic card_xfer_active_i,
  output logic cmd_start_o,
  output logic [15:0] cmd_word_o,
  output logic cmd_logic_reset_o,
  output logic data_logic_reset_o,
  output logic bus_4bit_o,
  output logic card_clock_pin_o,
  input wire logic third_data_pin_i
);

  ccdf_pkg::ccdf_state_t s_q;
  ccdf_pkg::ccdf_state_t s_d;

  // Byte-lane merge for register writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    lane_merge = (old & ~m) | (nw & m);
  endfunction

  logic [5:0] count;
  logic [6:0] margin;
  logic [6:0] level_bytes;
  logic full_flag;
  logic empty_flag;
  logic [2:0] nbytes;
  logic [31:0] pop_word;
  logic [31:0] ctl_word;
  logic [31:0] clk_word;
  logic [31:0] stat_a_word;
  logic [31:0] stat_b_word;
  logic [31:0] bufctl_word;
  logic [27:0] rx_total;

  assign count = s_q.wr_ptr - s_q.rd_ptr;
  // Access-width code 00..11 means 4..1 bytes per port access
  assign nbytes = 3'(3'd4 - {1'b0, s_q.access_width_sel});
  assign margin = {4'h0, nbytes};
  assign full_flag = ({1'b0, count} + margin) > 7'(`CCDF_DEPTH);
  assign empty_flag = {1'b0, count} < margin;
  assign level_bytes = s_q.level ? `CCDF_LVL_FULL : `CCDF_LVL_HALF;
  // Operands widened first: a self-sized product would keep only 16 bits and miss the last byte
  assign rx_total = {16'h0000, s_q.blen} * {12'h000, s_q.nblk};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pop
      // Lowest byte of the word comes from the oldest entry
      assign pop_word[8*g +: 8] = (3'(g) < nbytes) ?
        s_q.mem[5'(s_q.rd_ptr[4:0] + 5'(g))] : 8'h00;
    end
  endgenerate

  assign ctl_word = {24'h0, s_q.edge_sel, 3'h0, s_q.cmd_rst, s_q.dat_rst, s_q.width};
  assign clk_word = {23'h0, s_q.clk_en, s_q.clk_rate};
  assign stat_a_word = {29'h0, s_q.edge_det, s_q.tx_rdy, s_q.rx_rdy};
  assign stat_b_word = {16'h0, 2'h0, count, 5'h0, s_q.sync2, empty_flag, full_flag};
  assign bufctl_word = {27'h0, s_q.access_width_sel, s_q.level, s_q.dir, 1'b0};

  always_comb begin
    logic req;
    logic commit;
    logic wr;
    logic [5:0] adr;
    logic [31:0] rd;
    logic [31:0] tmp;
    logic push_bus;
    logic pop_bus;
    logic card_push;
    logic card_pop;
    logic rx_last;
    logic rise;
    logic fall;
    logic tx_fire;
    logic rx_fire;
    logic [5:0] cnt_next;
    req = wb_cyc_i & wb_stb_i;
    commit = req & s_q.ack;
    wr = wb_we_i;
    adr = wb_adr_i[7:2];
    rd = 32'h0000_0000;
    tmp = 32'h0000_0000;
    push_bus = 1'b0;
    pop_bus = 1'b0;
    card_push = 1'b0;
    card_pop = 1'b0;
    rx_last = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    tx_fire = 1'b0;
    rx_fire = 1'b0;
    cnt_next = 6'h00;
    s_d = s_q;
    s_d.cmd_start = 1'b0;
    s_d.tx_req = 1'b0;
    s_d.rx_req = 1'b0;

    // Registered ack: asserted one cycle after the request, effects at the sampling edge
    s_d.ack = req & ~s_q.ack;
    unique case (adr)
      `CCDF_OFF_CONTROL: rd = ctl_word;
      `CCDF_OFF_CARD_CLOCK: rd = clk_word;
      `CCDF_OFF_IRQ_MASK: rd = {29'h0, s_q.mask};
      `CCDF_OFF_STATUS_A: rd = stat_a_word;
      `CCDF_OFF_STATUS_B: rd = stat_b_word;
      `CCDF_OFF_BLOCK_LEN: rd = {20'h0, s_q.blen};
      `CCDF_OFF_BLOCK_CNT: rd = {16'h0, s_q.nblk};
      `CCDF_OFF_COMMAND_A: rd = {16'h0, s_q.cmd_a};
      `CCDF_OFF_BUF_CTL: rd = bufctl_word;
      `CCDF_OFF_RX_PORT1, `CCDF_OFF_RX_PORT2: rd = pop_word;
      default: rd = 32'h0000_0000;
    endcase
    if (req & ~s_q.ack) begin
      s_d.rdata = wr ? 32'h0000_0000 : rd;
    end

    if (commit & wr) begin
      unique case (adr)
        `CCDF_OFF_CONTROL: begin
          tmp = lane_merge(ctl_word, wb_dat_i, wb_sel_i);
          s_d.width = tmp[`CCDF_CTL_WIDTH];
          s_d.dat_rst = tmp[`CCDF_CTL_DAT_RST];
          s_d.cmd_rst = tmp[`CCDF_CTL_CMD_RST];
          s_d.edge_sel = tmp[`CCDF_CTL_EDGE_LO +: 2];
        end
        `CCDF_OFF_CARD_CLOCK: begin
          tmp = lane_merge(clk_word, wb_dat_i, wb_sel_i);
          s_d.clk_rate = tmp[7:0];
          s_d.clk_en = tmp[`CCDF_CLK_EN];
        end
        `CCDF_OFF_IRQ_MASK: begin
          tmp = lane_merge({29'h0, s_q.mask}, wb_dat_i, wb_sel_i);
          s_d.mask = tmp[2:0];
        end
        `CCDF_OFF_BLOCK_LEN: begin
          tmp = lane_merge({20'h0, s_q.blen}, wb_dat_i, wb_sel_i);
          s_d.blen = tmp[11:0];
        end
        `CCDF_OFF_BLOCK_CNT: begin
          tmp = lane_merge({16'h0, s_q.nblk}, wb_dat_i, wb_sel_i);
          s_d.nblk = tmp[15:0];
        end
        `CCDF_OFF_COMMAND_A: begin
          // Any write here sends a command; the kick is valid only after it
          tmp = lane_merge({16'h0, s_q.cmd_a}, wb_dat_i, wb_sel_i);
          s_d.cmd_a = tmp[15:0];
          s_d.cmd_start = 1'b1;
          s_d.cmd_pend = 1'b1;
        end
        `CCDF_OFF_COMMAND_B: begin
          if (wb_sel_i[0] & wb_dat_i[`CCDF_CB_KICK]) begin
            if (s_q.cmd_pend) begin
              tx_fire = 1'b1;
              s_d.cmd_pend = 1'b0;
            end else begin
              // A kick out of order repeats the last command
              s_d.cmd_start = 1'b1;
            end
          end
        end
        `CCDF_OFF_BUF_CTL: begin
          if (wb_sel_i[0]) begin
            s_d.dir = wb_dat_i[`CCDF_BC_DIR] ? ccdf_pkg::ccdf_dir_tx : ccdf_pkg::ccdf_dir_rx;
            s_d.level = wb_dat_i[`CCDF_BC_LEVEL];
            s_d.access_width_sel = wb_dat_i[`CCDF_BC_ACCESS_WIDTH_SEL_LO +: 2];
          end
        end
        `CCDF_OFF_TX_PORT1, `CCDF_OFF_TX_PORT2: begin
          push_bus = (s_q.dir == ccdf_pkg::ccdf_dir_tx) & ~full_flag;
        end
        default: begin
        end
      endcase
    end
    if (commit & ~wr) begin
      pop_bus = ((adr == `CCDF_OFF_RX_PORT1) | (adr == `CCDF_OFF_RX_PORT2)) &
        (s_q.dir == ccdf_pkg::ccdf_dir_rx) & ~empty_flag;
    end

    // Buffer side toward the card
    card_pop = (s_q.dir == ccdf_pkg::ccdf_dir_tx) & card_tx_take_i & (count != 6'h00);
    card_push = (s_q.dir == ccdf_pkg::ccdf_dir_rx) & card_rx_valid_i & (count != 6'(`CCDF_DEPTH));

    if (push_bus) begin
      for (int i = 0; i < 4; i++) begin
        if (3'(i) < nbytes) begin
          s_d.mem[5'(s_q.wr_ptr[4:0] + 5'(i))] = wb_dat_i[8*i +: 8];
        end
      end
      s_d.wr_ptr = 6'(s_q.wr_ptr + {3'h0, nbytes});
    end
    if (card_push) begin
      s_d.mem[s_q.wr_ptr[4:0]] = card_rx_data_i;
      s_d.wr_ptr = 6'(s_q.wr_ptr + 6'h01);
      s_d.rx_cnt = 28'(s_q.rx_cnt + 28'h000_0001);
      rx_last = (s_q.nblk != 16'h0000) & (28'(s_q.rx_cnt + 28'h000_0001) == rx_total);
    end
    if (pop_bus) begin
      s_d.rd_ptr = 6'(s_q.rd_ptr + {3'h0, nbytes});
    end
    if (card_pop) begin
      s_d.rd_ptr = 6'(s_q.rd_ptr + 6'h01);
    end
    cnt_next = s_d.wr_ptr - s_d.rd_ptr;

    // Transmit: one request below level, rearmed only by the DMA completion
    if (s_q.dir == ccdf_pkg::ccdf_dir_tx) begin
      if (s_q.tx_arm & ({1'b0, cnt_next} < level_bytes)) begin
        tx_fire = 1'b1;
      end
    end
    if (tx_fire) begin
      s_d.tx_arm = 1'b0;
    end else if (dma_done_i) begin
      s_d.tx_arm = 1'b1;
    end

    // Receive: one request per crossing of the level, plus the final byte
    if (s_q.dir == ccdf_pkg::ccdf_dir_rx) begin
      if (s_q.rx_arm & ({1'b0, cnt_next} >= level_bytes)) begin
        rx_fire = 1'b1;
        s_d.rx_arm = 1'b0;
      end else if ({1'b0, cnt_next} < level_bytes) begin
        s_d.rx_arm = 1'b1;
      end
      if (rx_last) begin
        rx_fire = 1'b1;
      end
    end
    s_d.tx_req = tx_fire;
    s_d.rx_req = rx_fire;

    // Flags: hardware set wins over the clearing access
    if (push_bus) begin
      s_d.tx_rdy = 1'b0;
    end
    if (pop_bus) begin
      s_d.rx_rdy = 1'b0;
    end
    if (commit & ~wr & (adr == `CCDF_OFF_STATUS_A)) begin
      s_d.edge_det = 1'b0;
    end
    if (tx_fire) begin
      s_d.tx_rdy = 1'b1;
    end
    if (rx_fire) begin
      s_d.rx_rdy = 1'b1;
    end

    // Third data line: two-stage synchroniser, then an edge compare
    s_d.sync1 = third_data_pin_i;
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    rise = s_q.sync2 & ~s_q.sync3;
    fall = ~s_q.sync2 & s_q.sync3;
    if ((s_q.edge_sel[0] & rise) | (s_q.edge_sel[1] & fall)) begin
      s_d.edge_det = 1'b1;
    end

    // Buffer reset clears pointers and transfer bookkeeping, not configuration
    if ((commit & wr & (adr == `CCDF_OFF_BUF_CTL) & wb_sel_i[0] & wb_dat_i[`CCDF_BC_RESET]) | s_q.dat_rst) begin
      s_d.wr_ptr = 6'h00;
      s_d.rd_ptr = 6'h00;
      s_d.rx_cnt = 28'h000_0000;
      s_d.tx_arm = 1'b0;
      s_d.rx_arm = 1'b1;
    end

    // Card clock divider: half period of rate+1 function clocks
    if (s_q.clk_en | card_xfer_active_i) begin
      if (s_q.div_cnt >= s_q.clk_rate) begin
        s_d.div_cnt = 8'h00;
        s_d.clk_out = ~s_q.clk_out;
      end else begin
        s_d.div_cnt = 8'(s_q.div_cnt + 8'h01);
      end
    end else begin
      s_d.div_cnt = 8'h00;
      s_d.clk_out = 1'b0;
    end
  end

  // Only the hardware reset restores defaults; nothing else touches configuration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.clk_rate <= `CCDF_RST_CLK_RATE;
      s_q.blen <= `CCDF_RST_BLOCK_LEN;
      s_q.nblk <= `CCDF_RST_BLOCK_CNT;
      s_q.dir <= ccdf_pkg::ccdf_dir_rx;
      s_q.rx_arm <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdata;
  assign dma_tx_req_o = s_q.tx_req;
  assign dma_rx_req_o = s_q.rx_req;
  assign tx_ready_irq_o = s_q.tx_rdy & s_q.mask[`CCDF_IM_TX];
  assign rx_ready_irq_o = s_q.rx_rdy & s_q.mask[`CCDF_IM_RX];
  assign edge_irq_o = s_q.edge_det & s_q.mask[`CCDF_IM_EDGE];
  assign card_tx_valid_o = (s_q.dir == ccdf_pkg::ccdf_dir_tx) & (count != 6'h00);
  assign card_tx_data_o = s_q.mem[s_q.rd_ptr[4:0]];
  assign card_tx_dry_o = (s_q.dir == ccdf_pkg::ccdf_dir_tx) & (count == 6'h00);
  assign card_rx_ready_o = (s_q.dir == ccdf_pkg::ccdf_dir_rx) & (count != 6'(`CCDF_DEPTH));
  assign cmd_start_o = s_q.cmd_start;
  assign cmd_word_o = s_q.cmd_a;
  assign cmd_logic_reset_o = s_q.cmd_rst;
  assign data_logic_reset_o = s_q.dat_rst;
  assign bus_4bit_o = s_q.width;
  assign card_clock_pin_o = s_q.clk_out;

endmodule // ccdf_data_buffer

/* ccdf_cfg.svh */
// Depth, levels, offsets, field positions and reset values of the card data buffer
`ifndef CCDF_CFG_SVH
`define CCDF_CFG_SVH

`define CCDF_DEPTH 32
`define CCDF_PTR_W 6
`define CCDF_IDX_W 5
`define CCDF_LVL_HALF 7'h10
`define CCDF_LVL_FULL 7'h20

`define CCDF_OFF_CONTROL 6'h00
`define CCDF_OFF_CARD_CLOCK 6'h01
`define CCDF_OFF_IRQ_MASK 6'h02
`define CCDF_OFF_STATUS_A 6'h03
`define CCDF_OFF_STATUS_B 6'h04
`define CCDF_OFF_BLOCK_LEN 6'h05
`define CCDF_OFF_BLOCK_CNT 6'h06
`define CCDF_OFF_COMMAND_A 6'h07
`define CCDF_OFF_COMMAND_B 6'h08
`define CCDF_OFF_BUF_CTL 6'h09
`define CCDF_OFF_TX_PORT1 6'h0a
`define CCDF_OFF_TX_PORT2 6'h0b
`define CCDF_OFF_RX_PORT1 6'h0c
`define CCDF_OFF_RX_PORT2 6'h0d

`define CCDF_CTL_WIDTH 0
`define CCDF_CTL_DAT_RST 1
`define CCDF_CTL_CMD_RST 2
`define CCDF_CTL_EDGE_LO 6
`define CCDF_CLK_EN 8
`define CCDF_IM_RX 0
`define CCDF_IM_TX 1
`define CCDF_IM_EDGE 2
`define CCDF_BC_RESET 0
`define CCDF_BC_DIR 1
`define CCDF_BC_LEVEL 2
`define CCDF_BC_ACCESS_WIDTH_SEL_LO 3
`define CCDF_CB_KICK 0

`define CCDF_RST_CLK_RATE 8'hff
`define CCDF_RST_BLOCK_LEN 12'h200
`define CCDF_RST_BLOCK_CNT 16'h0000

`endif

/* ccdf_pkg.sv */
// Types of the card data buffer
package ccdf_pkg;

  typedef enum logic {
    ccdf_dir_rx,
    ccdf_dir_tx
  } ccdf_dir_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [31:0][7:0] mem;
    logic [5:0] wr_ptr;
    logic [5:0] rd_ptr;
    logic width;
    logic cmd_rst;
    logic dat_rst;
    logic [1:0] edge_sel;
    logic [7:0] clk_rate;
    logic clk_en;
    logic [2:0] mask;
    logic [11:0] blen;
    logic [15:0] nblk;
    logic [15:0] cmd_a;
    ccdf_dir_t dir;
    logic [1:0] access_width_sel;
    logic level;
    logic rx_rdy;
    logic tx_rdy;
    logic edge_det;
    logic tx_arm;
    logic rx_arm;
    logic [27:0] rx_cnt;
    logic cmd_pend;
    logic cmd_start;
    logic tx_req;
    logic rx_req;
    logic sync1;
    logic sync2;
    logic sync3;
    logic [7:0] div_cnt;
    logic clk_out;
  } ccdf_state_t;

endpackage

/* ccdf_card_model.sv */
// Behavioural card-transfer side facing the data buffer
`timescale 1ns/1ps
module ccdf_card_model (
  input wire logic clk_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_take_o,
  input wire logic take_en_i,
  input wire logic rx_ready_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  input wire logic [7:0] rx_n_i,
  output logic xfer_o
);
  logic [7:0] k = 8'h00;
  logic [7:0] n_got = 8'h00;
  logic [7:0] got [256];
  // Stalls while the bench withholds take_en_i, as a card waiting on its own clock
  assign tx_take_o = take_en_i;
  assign rx_valid_o = k < rx_n_i;
  // Between bytes the line shows the inverse of the last byte, never a stale copy
  assign rx_data_o = rx_valid_o ? 8'h40 + k : ~(8'h3f + k);
  assign xfer_o = take_en_i || rx_valid_o;
  always @(posedge clk_i) begin
    if (rx_valid_o && rx_ready_i)
      k <= k + 8'h01;
    if (tx_take_o && tx_valid_i) begin
      got[n_got] <= tx_data_i;
      n_got <= n_got + 8'h01;
    end
  end
endmodule // ccdf_card_model

/* ccdf_data_buffer_checker.sv */
// Port assertions of the card data buffer
`timescale 1ns/1ps
module ccdf_data_buffer_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic dma_tx_req_o,
  input wire logic dma_rx_req_o,
  input wire logic dma_done_i,
  input wire logic card_tx_valid_o,
  input wire logic card_tx_dry_o,
  input wire logic card_rx_ready_o,
  input wire logic cmd_start_o,
  input wire logic bus_4bit_o,
  input wire logic card_clock_pin_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_TX_HOLD: assert property (dma_tx_req_o |=> !dma_tx_req_o until dma_done_i)
    else $error("tx request before dma done");
  AST_RX_PULSE: assert property (dma_rx_req_o |=> !dma_rx_req_o)
    else $error("rx request not a pulse");
  AST_DRY_EXCL: assert property (card_tx_dry_o |-> !card_tx_valid_o)
    else $error("dry while valid");
  AST_DIR_EXCL: assert property (card_rx_ready_o |-> !card_tx_valid_o && !card_tx_dry_o)
    else $error("both directions active");
  AST_CMD_PULSE: assert property (cmd_start_o |=> !cmd_start_o)
    else $error("command start not a pulse");
  AST_RST_OUT: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !dma_tx_req_o && !dma_rx_req_o
    && !card_clock_pin_o && !bus_4bit_o && !cmd_start_o)
    else $error("output set after reset");
endmodule // ccdf_data_buffer_checker

bind ccdf_data_buffer ccdf_data_buffer_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .dma_tx_req_o(dma_tx_req_o), .dma_rx_req_o(dma_rx_req_o),
  .dma_done_i(dma_done_i), .card_tx_valid_o(card_tx_valid_o), .card_tx_dry_o(card_tx_dry_o),
  .card_rx_ready_o(card_rx_ready_o), .cmd_start_o(cmd_start_o), .bus_4bit_o(bus_4bit_o),
  .card_clock_pin_o(card_clock_pin_o));

/* ccdf_data_buffer_tb.sv */
// Self-checking bench of the card data buffer
`timescale 1ns/1ps
module ccdf_data_buffer_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, dma_done_i = 1'b0, third_data_pin_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, dma_tx_req_o, dma_rx_req_o, tx_ready_irq_o, rx_ready_irq_o, edge_irq_o, card_tx_valid_o;
  logic card_tx_take_i, card_tx_dry_o, card_rx_valid_i, card_rx_ready_o, card_xfer_active_i, cmd_start_o;
  logic cmd_logic_reset_o, data_logic_reset_o, bus_4bit_o, card_clock_pin_o;
  logic [7:0] card_tx_data_o, card_rx_data_i;
  logic [15:0] cmd_word_o;
  logic take_en = 1'b0;
  logic [7:0] rx_n = 8'h00;
  int n_mismatch = 0, compares = 0, cyc_n = 0, n_txr = 0, n_rxr = 0, n_cmd = 0;
  ccdf_data_buffer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .dma_tx_req_o(dma_tx_req_o), .dma_rx_req_o(dma_rx_req_o), .dma_done_i(dma_done_i),
    .tx_ready_irq_o(tx_ready_irq_o), .rx_ready_irq_o(rx_ready_irq_o), .edge_irq_o(edge_irq_o),
    .card_tx_valid_o(card_tx_valid_o), .card_tx_data_o(card_tx_data_o), .card_tx_take_i(card_tx_take_i),
    .card_tx_dry_o(card_tx_dry_o), .card_rx_valid_i(card_rx_valid_i), .card_rx_data_i(card_rx_data_i),
    .card_rx_ready_o(card_rx_ready_o), .card_xfer_active_i(card_xfer_active_i), .cmd_start_o(cmd_start_o),
    .cmd_word_o(cmd_word_o), .cmd_logic_reset_o(cmd_logic_reset_o), .data_logic_reset_o(data_logic_reset_o),
    .bus_4bit_o(bus_4bit_o), .card_clock_pin_o(card_clock_pin_o), .third_data_pin_i(third_data_pin_i));
  ccdf_card_model card (.clk_i(clk_i), .tx_valid_i(card_tx_valid_o), .tx_data_i(card_tx_data_o),
    .tx_take_o(card_tx_take_i), .take_en_i(take_en), .rx_ready_i(card_rx_ready_o),
    .rx_valid_o(card_rx_valid_i), .rx_data_o(card_rx_data_i), .rx_n_i(rx_n), .xfer_o(card_xfer_active_i));
  initial forever #4 clk_i = ~clk_i;
  task automatic stop_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    n_txr <= n_txr + int'(dma_tx_req_o);
    n_rxr <= n_rxr + int'(dma_rx_req_o);
    n_cmd <= n_cmd + int'(cmd_start_o);
    if (cyc_n == 20000) begin
      n_mismatch++;
      stop_test;
    end
  end
  task automatic cy(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // Request held until the sampled ack; released only at that edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    logic [31:0] r;
    wb(1'b0, a, 32'h0000_0000, r);
    chk(r, e, m);
  endtask
  task automatic rise;
    while (card_clock_pin_o !== 1'b0) cy(1);
    while (card_clock_pin_o !== 1'b1) cy(1);
  endtask
  task automatic t_init;
    rd(8'h04, 32'h0000_00ff, "clock reg");
    rd(8'h14, 32'h0000_0200, "blen reg");
    rd(8'h10, 32'h0000_0002, "status b");
    rd(8'hfc, 32'h0000_0000, "unmapped");
    wr(8'h00, 32'h0000_0006);
    cy(1);
    chk({cmd_logic_reset_o, data_logic_reset_o}, 8'h03, "resets set");
    wr(8'h00, 32'h0000_0000);
    cy(1);
    chk({cmd_logic_reset_o, data_logic_reset_o}, 8'h00, "resets clear");
  endtask
  task automatic t_fill;
    wr(8'h24, 32'h0000_0003);
    for (int i = 0; i < 9; i++) wr(8'h28, 32'h0302_0100 + i * 32'h0404_0404);
    rd(8'h10, 32'h0000_2001, "full");
    take_en <= 1'b1;
    cy(40);
    take_en <= 1'b0;
    chk(card.n_got, 8'h20, "bytes out");
    for (int j = 0; j < 32; j++) chk(card.got[j], j, "byte order");
    chk(card_tx_dry_o, 1'h1, "dry");
    rd(8'h10, 32'h0000_0002, "empty");
    // Pointers now stand at 32, so this word lands in entries 0 to 3 again
    wr(8'h28, 32'h2322_2120);
    take_en <= 1'b1;
    cy(8);
    take_en <= 1'b0;
    chk(card.got[32], 8'h20, "wrapped byte");
    chk(card.got[35], 8'h23, "wrapped last byte");
  endtask
  task automatic t_rx;
    int b;
    wr(8'h24, 32'h0000_0001);
    wr(8'h08, 32'h0000_0001);
    wr(8'h14, 32'h0000_0014);
    wr(8'h18, 32'h0000_0001);
    b = n_rxr;
    rx_n <= 8'h14;
    cy(30);
    chk(n_rxr - b, 8'h02, "rx requests");
    chk(rx_ready_irq_o, 1'h1, "rx irq");
    rd(8'h30, 32'h4342_4140, "rx word");
    wr(8'h24, 32'h0000_0018);
    rd(8'h34, 32'h0000_0044, "rx byte");
    rd(8'h10, 32'h0000_0f00, "count 15");
    chk(rx_ready_irq_o, 1'h0, "rx flag pop");
    wr(8'h24, 32'h0000_0005);
    b = n_rxr;
    rx_n <= 8'h28;
    cy(30);
    chk(n_rxr - b, 8'h01, "rx requests level 32");
    chk(rx_ready_irq_o, 1'h1, "rx irq last byte");
    rd(8'h30, 32'h5756_5554, "rx word level 32");
  endtask
  task automatic t_dma;
    int t, c;
    wr(8'h24, 32'h0000_0003);
    wr(8'h08, 32'h0000_0002);
    t = n_txr;
    c = n_cmd;
    wr(8'h1c, 32'h0000_0011);
    wr(8'h20, 32'h0000_0001);
    cy(10);
    chk(n_cmd - c, 8'h01, "cmd start");
    chk(cmd_word_o, 16'h0011, "cmd word");
    chk(n_txr - t, 8'h01, "kick");
    chk(tx_ready_irq_o, 1'h1, "tx irq");
    dma_done_i <= 1'b1;
    cy(1);
    dma_done_i <= 1'b0;
    cy(6);
    chk(n_txr - t, 8'h02, "rearm");
    wr(8'h28, 32'h0706_0504);
    cy(1);
    chk(tx_ready_irq_o, 1'h0, "tx flag push");
  endtask
  task automatic t_clock;
    int t0;
    wr(8'h04, 32'h0000_0102);
    rise;
    t0 = cyc_n;
    rise;
    chk(cyc_n - t0, 8'h06, "clock period");
    wr(8'h04, 32'h0000_0002);
    cy(4);
    for (int i = 0; i < 12; i++) begin
      cy(1);
      chk(card_clock_pin_o, 1'h0, "clock parked");
    end
    take_en <= 1'b1;
    rise;
    cy(8);
    take_en <= 1'b0;
    chk(card.got[36], 8'h04, "byte while clocked");
  endtask
  task automatic t_edge;
    wr(8'h00, 32'h0000_0041);
    wr(8'h08, 32'h0000_0004);
    cy(1);
    chk(bus_4bit_o, 1'h1, "4-bit bus");
    third_data_pin_i <= 1'b1;
    cy(6);
    chk(edge_irq_o, 1'h1, "edge irq");
    rd(8'h0c, 32'h0000_0004, "edge flag");
    cy(1);
    chk(edge_irq_o, 1'h0, "edge clear");
    wr(8'h00, 32'h0000_0000);
    cy(1);
    chk(bus_4bit_o, 1'h0, "1-bit bus");
  endtask
  // Mid-run hardware reset: configuration written earlier must fall back to defaults
  task automatic t_reset;
    rst_i <= 1'b1;
    cy(2);
    rst_i <= 1'b0;
    rd(8'h04, 32'h0000_00ff, "clock reg after reset");
    rd(8'h24, 32'h0000_0000, "buffer ctl after reset");
    rd(8'h08, 32'h0000_0000, "mask after reset");
    rd(8'h10, 32'h0000_0006, "status b after reset");
  endtask
  initial begin
    cy(16);
    rst_i <= 1'b0;
    t_init;
    t_fill;
    t_rx;
    t_dma;
    t_clock;
    t_edge;
    t_reset;
    stop_test;
  end
endmodule // ccdf_data_buffer_tb
